// ==== flash_pm_pkg.sv ====
// Package: constants and types for the flash reset and power-management command block.
package flash_pm_pkg;

    // Opcodes.
    localparam logic [7:0] OP_LEGACY_RESET   = 8'hf0;
    localparam logic [7:0] OP_MODE_BIT_CLEAR = 8'hff;
    localparam logic [7:0] OP_SLEEP_ENTRY    = 8'hb9;
    localparam logic [7:0] OP_WAKE           = 8'hab;
    localparam logic [7:0] OP_OTP_PROGRAM    = 8'h42;
    localparam logic [7:0] OP_LEARN_PROGRAM  = 8'h43;
    localparam logic [7:0] OP_PROT_PROGRAM   = 8'h2f;
    localparam logic [7:0] OP_PASS_PROGRAM   = 8'he8;
    localparam logic [7:0] OP_PPB_PROGRAM    = 8'he3;
    localparam logic [7:0] OP_PPB_ERASE      = 8'he4;

    // Clock rate in kHz (125 MHz).
    localparam int CLK_KHZ = 125000;

    // Times as printed, in their own units.
    localparam int SLEEP_ENTRY_TIME_NS = 3000;
    localparam int WAKE_TIME_NS        = 30000;
    localparam int SUSPEND_LATENCY_US  = 40;
    localparam int RESUME_SUSPEND_US   = 100;
    localparam int NV_WRITE_TYP_MS     = 240;
    localparam int NV_WRITE_MAX_MS     = 750;
    localparam int PAGE_PROG_MAX_US    = 2000;
    localparam int PAGE_PROG_512_US    = 475;
    localparam int PAGE_PROG_256_US    = 360;
    localparam int SECTOR_ERASE_TYP_MS = 930;
    localparam int SECTOR_ERASE_MAX_MS = 2900;
    localparam int SMALL_ERASE_TYP_MS  = 240;
    localparam int SMALL_ERASE_MAX_MS  = 725;
    localparam int EES_BIG_MAX_US      = 100;
    localparam int EES_SMALL_MAX_US    = 25;

    // Cycle counts (nanosecond and microsecond times round down).
    localparam int SLEEP_ENTRY_CYC   = SLEEP_ENTRY_TIME_NS * (CLK_KHZ / 1000) / 1000;
    localparam int WAKE_CYC          = WAKE_TIME_NS * (CLK_KHZ / 1000) / 1000;
    localparam int SUSPEND_CYC       = SUSPEND_LATENCY_US * (CLK_KHZ / 1000);
    localparam int NV_WRITE_CYC      = NV_WRITE_TYP_MS * CLK_KHZ;
    localparam int PAGE_PROG_CYC     = PAGE_PROG_512_US * (CLK_KHZ / 1000);
    localparam int SECTOR_ERASE_CYC  = SECTOR_ERASE_TYP_MS * CLK_KHZ;
    localparam int SMALL_ERASE_CYC   = SMALL_ERASE_TYP_MS * CLK_KHZ;
    localparam int EES_BIG_CYC       = EES_BIG_MAX_US * (CLK_KHZ / 1000);
    localparam int EES_SMALL_CYC     = EES_SMALL_MAX_US * (CLK_KHZ / 1000);

    // Shifter reset value and bit-count constants.
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [3:0] BITCNT_SIX  = 4'h6;
    localparam logic [3:0] BITCNT_EIGHT = 4'h8;

    // Embedded operation kinds started by the surrounding decoder.
    typedef enum logic [2:0]
    {
        OPK_PAGE_PROGRAM  = 3'h0,
        OPK_SECTOR_ERASE  = 3'h1,
        OPK_SMALL_ERASE   = 3'h2,
        OPK_NV_WRITE      = 3'h3,
        OPK_EES_BIG       = 3'h4,
        OPK_EES_SMALL     = 3'h5
    } op_kind_e;

    // Request to start an embedded operation.
    typedef struct packed
    {
        logic     start;
        op_kind_e kind;
    } op_req_s;

    // Power state reported outward.
    typedef struct packed
    {
        logic standby;
        logic entering;
        logic sleeping;
        logic waking;
    } power_state_s;

endpackage

// ==== flash_reset_pd_cmds.sv ====
// Module: reset, mode-bit clear and deep-sleep command handling with busy timing.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Legacy reset acts only when enable bit set
// - Mode-bit clear leaves continuous read mode
// - Sleep entry accepted only when not busy
// - Chip select must rise right after bit eight
// - Power-down reached within sleep entry time
// - Only wake decoded while powered down
// - Power-up always lands in standby
// - Commands accepted only after wake time
// - Wake returns no identification value
// - Hardware reset leaves power-down
// - Four-line mode: two clocks per byte
// - Suspend clears busy within forty microseconds
// - Register write busy for its write time
// - Page program busy within two milliseconds
// - Large sector erase busy for its time
// - Small sector erase busy for its time
// - Erase status evaluation busy for its time
// - OTP-like programs take page program time
// - Protection erase takes sector erase time
// - Busy flag high during any embedded operation
module flash_reset_pd_cmds
#(
    parameter int SLEEP_ENTRY_CYCLES  = flash_pm_pkg::SLEEP_ENTRY_CYC,
    parameter int WAKE_CYCLES         = flash_pm_pkg::WAKE_CYC,
    parameter int SUSPEND_CYCLES      = flash_pm_pkg::SUSPEND_CYC,
    parameter int NV_WRITE_CYCLES     = flash_pm_pkg::NV_WRITE_CYC,
    parameter int PAGE_PROG_CYCLES    = flash_pm_pkg::PAGE_PROG_CYC,
    parameter int SECTOR_ERASE_CYCLES = flash_pm_pkg::SECTOR_ERASE_CYC,
    parameter int SMALL_ERASE_CYCLES  = flash_pm_pkg::SMALL_ERASE_CYC,
    parameter int EES_BIG_CYCLES      = flash_pm_pkg::EES_BIG_CYC,
    parameter int EES_SMALL_CYCLES    = flash_pm_pkg::EES_SMALL_CYC
)
(
    // Clock and reset.
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    // Serial link pins from the host.
    input  wire logic                       chipSelect_n,
    input  wire logic                       serialClock,
    input  wire logic [3:0]                 dataIn,
    // Configuration and mode inputs from the rest of the device.
    input  wire logic                       legacyResetEnable,
    input  wire logic                       fourLineCommandMode,
    input  wire logic                       continuousReadActive,
    input  wire flash_pm_pkg::op_req_s      opRequest,
    input  wire logic                       suspendRequest,
    // Results.
    output logic                            writeInProgress,
    output logic                            continuousReadExit,
    output logic                            softwareReset,
    output flash_pm_pkg::power_state_s      powerState,
    output logic                            commandReady
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Chip select resets high and the serial clock low, the idle levels of
    // the pins, so that no false edge is seen as reset lifts. The data lines
    // pass the same two stages, which keeps them aligned with the clock edge
    // that the detector reports.
    logic [1:0] csSync;
    logic [1:0] sckSync;
    logic [3:0] dSync0;
    logic [3:0] dSync1;
    logic       sckLast;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            csSync  <= 2'h3;
            sckSync <= 2'h0;
            dSync0  <= 4'h0;
            dSync1  <= 4'h0;
            sckLast <= 1'b0;
        end
        else
        begin
            csSync  <= {csSync[0], chipSelect_n};
            sckSync <= {sckSync[0], serialClock};
            dSync0  <= dataIn;
            dSync1  <= dSync0;
            sckLast <= sckSync[1];
        end
    end

    logic csHigh;
    logic sckRise;
    assign csHigh  = csSync[1];
    assign sckRise = sckSync[1] & ~sckLast;

    // ------------------------------------------------------------------
    // Instruction shifter
    // ------------------------------------------------------------------
    // Only the first byte of a frame is kept; bits past the eighth mark the
    // frame as too long, so a trailing opcode never executes.
    // In four-line mode each serial clock carries a nibble, high nibble
    // first, so two rising edges fill the byte.
    logic [7:0] shift_reg;
    logic [3:0] bitCount_reg;
    logic       overrun_reg;
    logic       csLast;
    logic       frameEnd;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_reg    <= flash_pm_pkg::SHIFT_RESET;
            bitCount_reg <= 4'h0;
            overrun_reg  <= 1'b0;
            csLast       <= 1'b1;
        end
        else
        begin
            csLast <= csHigh;
            if (csHigh)
            begin
                bitCount_reg <= 4'h0;
                overrun_reg  <= 1'b0;
            end
            else if (sckRise)
            begin
                if (bitCount_reg == flash_pm_pkg::BITCNT_EIGHT)
                begin
                    overrun_reg <= 1'b1;
                end
                else if (fourLineCommandMode)
                begin
                    shift_reg    <= {shift_reg[3:0], dSync1};
                    bitCount_reg <= bitCount_reg + 4'h4;
                end
                else
                begin
                    shift_reg    <= {shift_reg[6:0], dSync1[0]};
                    bitCount_reg <= bitCount_reg + 4'h1;
                end
            end
        end
    end

    assign frameEnd = csHigh & ~csLast;

    logic byteOk;
    assign byteOk = frameEnd && (bitCount_reg == flash_pm_pkg::BITCNT_EIGHT) && !overrun_reg;

    // ------------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------------
    // The sleep opcode is qualified once here, so that the power machine and
    // the busy timer both act on the same decision.
    logic sleepAccept;
    logic wakeAccept;
    logic modeClearHit;
    logic legacyResetHit;

    assign sleepAccept    = byteOk && (shift_reg == flash_pm_pkg::OP_SLEEP_ENTRY)
                            && !writeInProgress;
    assign wakeAccept     = byteOk && (shift_reg == flash_pm_pkg::OP_WAKE);
    assign modeClearHit   = byteOk && (shift_reg == flash_pm_pkg::OP_MODE_BIT_CLEAR);
    assign legacyResetHit = byteOk && (shift_reg == flash_pm_pkg::OP_LEGACY_RESET);

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    typedef enum logic [3:0]
    {
        PS_STANDBY  = 4'b0001,
        PS_ENTERING = 4'b0010,
        PS_SLEEPING = 4'b0100,
        PS_WAKING   = 4'b1000
    } pstate_e;

    pstate_e   pState_reg;
    logic [31:0] pCount_reg;

    // Under reset the machine sits in standby, covering power-up and
    // hardware reset alike. The counter holds the cycles left in the entry
    // or wake wait; while it runs, every opcode is ignored.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pState_reg <= PS_STANDBY;
            pCount_reg <= 32'h0;
        end
        else
        begin
            unique case (pState_reg)
                PS_STANDBY:
                begin
                    if (sleepAccept)
                    begin
                        pState_reg <= PS_ENTERING;
                        pCount_reg <= 32'(SLEEP_ENTRY_CYCLES);
                    end
                end
                PS_ENTERING:
                begin
                    if (pCount_reg <= 32'h1)
                    begin
                        pState_reg <= PS_SLEEPING;
                    end
                    pCount_reg <= pCount_reg - 32'h1;
                end
                PS_SLEEPING:
                begin
                    if (wakeAccept)
                    begin
                        pState_reg <= PS_WAKING;
                        pCount_reg <= 32'(WAKE_CYCLES);
                    end
                end
                PS_WAKING:
                begin
                    if (pCount_reg <= 32'h1)
                    begin
                        pState_reg <= PS_STANDBY;
                    end
                    pCount_reg <= pCount_reg - 32'h1;
                end
            endcase
        end
    end

    logic awake;
    assign awake = (pState_reg == PS_STANDBY);

    // ------------------------------------------------------------------
    // Standby commands
    // ------------------------------------------------------------------
    // A wake opcode in standby falls through every branch, leaving state as is.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            continuousReadExit <= 1'b0;
            softwareReset      <= 1'b0;
        end
        else
        begin
            continuousReadExit <= modeClearHit && awake && continuousReadActive;
            softwareReset      <= legacyResetHit && awake && legacyResetEnable
                                  && !continuousReadActive;
        end
    end

    // ------------------------------------------------------------------
    // Embedded operation busy timer
    // ------------------------------------------------------------------
    // Program, erase and register-write loads use the typical figures, and the
    // erase-status loads the longest; a user needing worst-case timing must
    // override the parameters.
    logic [31:0] busyCount_reg;
    logic [31:0] busyLoad;
    logic        opStart;

    // A start in the cycle that accepts sleep entry is refused, so that no
    // operation can begin on its way into power-down.
    assign opStart = opRequest.start && !writeInProgress && awake && !sleepAccept;

    always_comb
    begin
        unique case (opRequest.kind)
            flash_pm_pkg::OPK_PAGE_PROGRAM: busyLoad = 32'(PAGE_PROG_CYCLES);
            flash_pm_pkg::OPK_SECTOR_ERASE: busyLoad = 32'(SECTOR_ERASE_CYCLES);
            flash_pm_pkg::OPK_SMALL_ERASE:  busyLoad = 32'(SMALL_ERASE_CYCLES);
            flash_pm_pkg::OPK_NV_WRITE:     busyLoad = 32'(NV_WRITE_CYCLES);
            flash_pm_pkg::OPK_EES_BIG:      busyLoad = 32'(EES_BIG_CYCLES);
            flash_pm_pkg::OPK_EES_SMALL:    busyLoad = 32'(EES_SMALL_CYCLES);
            default:                        busyLoad = 32'(PAGE_PROG_CYCLES);
        endcase
    end

    // Suspend trims the remaining busy time to the suspend latency.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busyCount_reg   <= 32'h0;
            writeInProgress <= 1'b0;
        end
        else
        begin
            if (opStart)
            begin
                busyCount_reg   <= busyLoad;
                writeInProgress <= 1'b1;
            end
            else if (writeInProgress)
            begin
                if (suspendRequest && busyCount_reg > 32'(SUSPEND_CYCLES))
                begin
                    busyCount_reg <= 32'(SUSPEND_CYCLES);
                end
                else if (busyCount_reg <= 32'h1)
                begin
                    busyCount_reg   <= 32'h0;
                    writeInProgress <= 1'b0;
                end
                else
                begin
                    busyCount_reg <= busyCount_reg - 32'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The power state is registered once more so that every output leaves a
    // flip-flop. It and commandReady trail the internal machine by one
    // cycle, which the host never sees because chip select must stay high
    // for the whole wake time.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerState   <= '{standby: 1'b1, entering: 1'b0, sleeping: 1'b0, waking: 1'b0};
            commandReady <= 1'b0;
        end
        else
        begin
            powerState.standby  <= (pState_reg == PS_STANDBY);
            powerState.entering <= (pState_reg == PS_ENTERING);
            powerState.sleeping <= (pState_reg == PS_SLEEPING);
            powerState.waking   <= (pState_reg == PS_WAKING);
            commandReady        <= awake;
        end
    end

endmodule
`default_nettype wire

// ==== flash_host_model.sv ====
// Host-side driver that frames opcodes on the serial link pins.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model
(
    // Clock.
    input  wire logic       clock,
    // Link pins.
    output logic            chipSelect_n,
    output logic            serialClock,
    output logic [3:0]      dataIn
);
    initial
    begin
        chipSelect_n = 1'b1;
        serialClock  = 1'b0;
        dataIn       = 4'h0;
    end

    // Half of a 64 ns serial clock period is four system clocks.
    task automatic half();
        repeat (4) @(negedge clock);
    endtask

    task automatic frame(input logic [7:0] op, input logic quad, input int extra);
        int n;
        n = (quad ? 2 : 8) + extra;
        half();
        chipSelect_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            if (quad)
                dataIn = (i == 0) ? op[7:4] : op[3:0];
            else
                dataIn = {3'($urandom), op[7 - (i % 8)]};
            half();
            serialClock = 1'b1;
            half();
            serialClock = 1'b0;
        end
        chipSelect_n = 1'b1;
        // Released lines show the inverse so a stale value is never mistaken for data.
        dataIn = ~dataIn;
        repeat (40) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// ==== flash_reset_pd_cmds_assertions.sv ====
// Checker for the reset and power-down command block.
`timescale 1ns/1ps
`default_nettype none
module flash_reset_pd_cmds_assertions
#(
    parameter int SLEEP_ENTRY_CYCLES = 10,
    parameter int WAKE_CYCLES        = 20,
    parameter int SUSPEND_CYCLES     = 20
)
(
    input wire logic                       clock,
    input wire logic                       reset_n,
    input wire logic                       legacyResetEnable,
    input wire logic                       continuousReadActive,
    input wire flash_pm_pkg::op_req_s      opRequest,
    input wire logic                       suspendRequest,
    input wire logic                       writeInProgress,
    input wire logic                       continuousReadExit,
    input wire logic                       softwareReset,
    input wire flash_pm_pkg::power_state_s powerState,
    input wire logic                       commandReady
);
    localparam int SE_MAX = SLEEP_ENTRY_CYCLES + 2;
    localparam int WK_MAX = WAKE_CYCLES + 2;
    localparam int SU_MAX = SUSPEND_CYCLES + 2;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_legacy_gate: assert property (
        softwareReset |-> $past(legacyResetEnable) && !$past(continuousReadActive))
        else $error("legacy reset while disabled");
    chk_exit_gate: assert property (
        continuousReadExit |-> $past(continuousReadActive))
        else $error("mode exit outside continuous read");
    chk_sleep_idle: assert property (
        $rose(powerState.entering) |-> !writeInProgress && !$past(writeInProgress))
        else $error("sleep entered while busy");
    chk_entry_time: assert property (
        $rose(powerState.entering) |-> ##[1:SE_MAX] powerState.sleeping)
        else $error("sleep not reached in time");
    chk_sleep_deaf: assert property (
        powerState.sleeping |-> !continuousReadExit && !softwareReset
            && !commandReady && !writeInProgress)
        else $error("activity while asleep");
    chk_wake_hold: assert property (
        $rose(powerState.waking) |=> (!commandReady)[*8] ##[1:WK_MAX] commandReady)
        else $error("wake time wrong");
    chk_wake_source: assert property (
        $rose(powerState.waking) |-> $past(powerState.sleeping))
        else $error("wake left a state other than sleep");
    chk_busy_start: assert property (
        opRequest.start && !writeInProgress && powerState.standby
            |=> (writeInProgress or ##1 powerState.entering))
        else $error("busy flag not raised");
    chk_suspend_cap: assert property (
        suspendRequest && writeInProgress |-> ##[0:SU_MAX] !writeInProgress)
        else $error("suspend latency exceeded");
    chk_state_onehot: assert property ($onehot(powerState))
        else $error("power state not one-hot");
endmodule
`default_nettype wire

// ==== flash_reset_pd_cmds_tb.sv ====
// Testbench for the reset and power-down command block.
`timescale 1ns/1ps
`default_nettype none
module flash_reset_pd_cmds_tb;
    localparam int SE = 10, WK = 20, SU = 15;
    localparam int BUSY [6] = '{300, 800, 500, 600, 200, 100};
    logic clock = 1'b0;
    logic reset_n, legEn, quadMode, contRead, suspReq;
    logic chipSelect_n, serialClock, write_in_progress, crExit, swReset, cmdReady;
    logic [3:0] dataIn;
    flash_pm_pkg::op_req_s opReq;
    flash_pm_pkg::power_state_s pState;
    int err_total = 0, check_count = 0, cycles = 0;
    int swCnt = 0, exitCnt = 0, wakeLen = 0, len, k, q, sa;

    initial forever #4 clock = ~clock;

    flash_host_model u_flash_host_model (.clock(clock), .chipSelect_n(chipSelect_n),
        .serialClock(serialClock), .dataIn(dataIn));
    flash_reset_pd_cmds #(.SLEEP_ENTRY_CYCLES(SE), .WAKE_CYCLES(WK),
        .SUSPEND_CYCLES(SU), .PAGE_PROG_CYCLES(BUSY[0]), .SECTOR_ERASE_CYCLES(BUSY[1]),
        .SMALL_ERASE_CYCLES(BUSY[2]), .NV_WRITE_CYCLES(BUSY[3]),
        .EES_BIG_CYCLES(BUSY[4]), .EES_SMALL_CYCLES(BUSY[5])) u_flash_reset_pd_cmds (
        .clock(clock), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
        .serialClock(serialClock), .dataIn(dataIn), .legacyResetEnable(legEn),
        .fourLineCommandMode(quadMode), .continuousReadActive(contRead),
        .opRequest(opReq), .suspendRequest(suspReq), .writeInProgress(write_in_progress),
        .continuousReadExit(crExit), .softwareReset(swReset), .powerState(pState),
        .commandReady(cmdReady));

    always @(negedge clock)
    begin
        cycles++;
        if (swReset === 1'b1) swCnt++;
        if (crExit === 1'b1) exitCnt++;
        if (pState.waking === 1'b1) wakeLen++;
        if (cycles == 20000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] op, input logic quad, input int extra);
        @(negedge clock);
        quadMode = quad;
        u_flash_host_model.frame(op, quad, extra);
    endtask

    // Runs one embedded operation; a suspend pulse goes out after sus busy cycles.
    task automatic run_op(input int kind, input int sus, output int n);
        @(negedge clock);
        opReq = '{1'b1, flash_pm_pkg::op_kind_e'(kind[2:0])};
        @(negedge clock);
        opReq.start = 1'b0;
        n = 0;
        repeat (3) if (write_in_progress !== 1'b1) @(negedge clock);
        while (write_in_progress === 1'b1 && n < 2000)
        begin
            suspReq = (n == sus);
            @(negedge clock);
            n++;
        end
        suspReq = 1'b0;
    endtask

    initial
    begin
        q = $urandom(40044);
        {reset_n, legEn, quadMode, contRead, suspReq} = 5'h00;
        opReq = '0;
        repeat (16) @(posedge clock);
        @(negedge clock) reset_n = 1'b1;
        repeat (4) @(negedge clock);
        check("state", pState, 4'h8);
        check("ready", cmdReady, 1);
        contRead = 1'b1;
        send(flash_pm_pkg::OP_MODE_BIT_CLEAR, 0, 0);
        send(flash_pm_pkg::OP_MODE_BIT_CLEAR, 1, 0);
        check("exits", exitCnt, 2);
        contRead = 1'b0;
        send(flash_pm_pkg::OP_LEGACY_RESET, 0, 0);
        check("reset off", swCnt, 0);
        legEn = 1'b1;
        send(flash_pm_pkg::OP_LEGACY_RESET, $urandom % 2, 0);
        check("reset on", swCnt, 1);
        $display("end of test: commands");
        for (k = 0; k < 6; k++)
        begin
            run_op(k, -1, len);
            check("busy", len, BUSY[k]);
        end
        k = $urandom % 6;
        sa = $urandom_range(20, 1);
        run_op(k, sa, len);
        check("suspend", (len > sa) && (len <= sa + SU + 1), 1);
        $display("end of test: busy");
        fork
            run_op(3, -1, len);
            begin
                repeat (5) @(negedge clock);
                send(flash_pm_pkg::OP_SLEEP_ENTRY, 0, 0);
                check("busy sleep", pState, 4'h8);
            end
        join
        send(flash_pm_pkg::OP_SLEEP_ENTRY, 0, 1);
        check("long frame", pState, 4'h8);
        send(flash_pm_pkg::OP_SLEEP_ENTRY, q[0], 0);
        check("asleep", pState, 4'h2);
        contRead = 1'b1;
        send(flash_pm_pkg::OP_MODE_BIT_CLEAR, 0, 0);
        contRead = 1'b0;
        send(flash_pm_pkg::OP_LEGACY_RESET, 0, 0);
        run_op(0, -1, len);
        check("deaf", {swCnt[3:0], exitCnt[3:0], len[3:0], pState}, 16'h1202);
        send(flash_pm_pkg::OP_WAKE, $urandom % 2, 0);
        check("wake len", wakeLen, WK);
        check("awake", {cmdReady, pState}, 5'h18);
        send(flash_pm_pkg::OP_WAKE, 0, 0);
        check("idle wake", {wakeLen[7:0], pState}, {8'(WK), 4'h8});
        send(flash_pm_pkg::OP_SLEEP_ENTRY, 0, 0);
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        check("hw reset", pState, 4'h8);
        $display("end of test: power");
        stop_test();
    end
endmodule

bind flash_reset_pd_cmds flash_reset_pd_cmds_assertions #(
    .SLEEP_ENTRY_CYCLES(SLEEP_ENTRY_CYCLES), .WAKE_CYCLES(WAKE_CYCLES),
    .SUSPEND_CYCLES(SUSPEND_CYCLES)) u_chk (
    .clock(clock), .reset_n(reset_n), .legacyResetEnable(legacyResetEnable),
    .continuousReadActive(continuousReadActive), .opRequest(opRequest),
    .suspendRequest(suspendRequest), .writeInProgress(writeInProgress),
    .continuousReadExit(continuousReadExit), .softwareReset(softwareReset),
    .powerState(powerState), .commandReady(commandReady));
`default_nettype wire
